// >>> pkg/pdw_regs.svh
// Register offsets, command codes, field positions and reset values of the
// power-down and wakeup controller. Included by bare name; definitions only.
`ifndef PDW_REGS_SVH
`define PDW_REGS_SVH

// Register word indices on the plain register port.
`define PDW_A_CMD       4'h0
`define PDW_A_WAKE_A    4'h1
`define PDW_A_WAKE_B    4'h2
`define PDW_A_WAKE_C    4'h3
`define PDW_A_EXT_IRQ_PIN_A_CTL  4'h4
`define PDW_A_EXT_IRQ_PIN_B_CTL  4'h5
`define PDW_A_STATUS    4'h6
`define PDW_A_CTX       4'h7
`define PDW_A_IRQ_STAT  4'h8
`define PDW_A_IRQ_CLR   4'h9
`define PDW_A_IRQ_EN    4'ha

// Command codes written to the command register.
`define PDW_OP_ARM      4'h1
`define PDW_OP_ENTER    4'h2
`define PDW_OP_DEEP     4'h3
`define PDW_OP_WDT_RST  4'h4
`define PDW_OP_WDT_STOP 4'h5
`define PDW_OP_SEL_CER  4'h6
`define PDW_OP_SEL_RC   4'h7
`define PDW_OP_INT_MASK 4'h8

// Field positions.
`define PDW_INT_EN_BIT  3
`define PDW_WK_C_PIN_A  0
`define PDW_WK_C_PIN_B  2
`define PDW_EV_WAKE     0
`define PDW_EV_NO_ARM   1
`define PDW_EV_EXT_CLK  2
`define PDW_EV_SEL_IGN  3
`define PDW_EV_INT_A    4
`define PDW_EV_INT_B    5

// Context of pointers and auxiliaries: Z[1:0] X[5:2] Y[9:6] D[12:10] E[20:13].
// Undefined contents are modelled by a fixed scramble pattern.
`define PDW_CTX_POISON  21'h0aa556
`define PDW_CTX_RST     21'h0aa402
`define PDW_STAB_EDGES  16

`endif

// >>> pkg/pdw_pkg.sv
// Types of the power-down and wakeup controller.
// Assumes the register header is on the include path.
`default_nettype none
package pdw_pkg;

    typedef enum logic [2:0] {
        ST_STAB = 3'b001,
        ST_RUN  = 3'b010,
        ST_HALT = 3'b100
    } pdw_state_t;

    typedef struct packed {
        pdw_state_t  st;
        logic        arm;
        logic        deep;
        logic        wdt_stop_seen;
        logic        wdt_en;
        logic [1:0]  osc_sel;
        logic        onchip_en;
        logic        ext_clk;
        logic [3:0]  wk_a;
        logic [3:0]  wk_b;
        logic [3:0]  wk_c;
        logic [3:0]  ext_irq_pin_a_ctl;
        logic [3:0]  ext_irq_pin_b_ctl;
        logic [20:0] ctx;
        logic [5:0]  irq_stat;
        logic [5:0]  irq_en;
        logic        irq;
        logic [31:0] rdata;
        logic        pin_a_d;
        logic        pin_b_d;
    } pdw_regs_t;

endpackage
`default_nettype wire

// >>> verilog/pdw_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous levels; only q is read outside.
`default_nettype none
module pdw_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // pdw_sync
`default_nettype wire

// >>> verilog/pdw_stab_timer.sv
// Oscillation stabilisation wait, counted in on-chip oscillator edges.
// Assumes osc is already synchronised to clk and is much slower than clk.
`default_nettype none
module pdw_stab_timer #(
    parameter int EDGES = 16
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic osc,
    output logic      done
);
    localparam int CW = $clog2(EDGES + 1);
    logic [CW-1:0] cnt_r;
    logic          osc_d_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r   <= '0;
            osc_d_r <= 1'b0;
            done    <= 1'b0;
        end else begin
            osc_d_r <= osc;
            if (!done && osc && !osc_d_r) begin
                cnt_r <= cnt_r + 1'b1;
                done  <= (cnt_r == CW'(EDGES - 1));
            end
        end
    end
endmodule // pdw_stab_timer
`default_nettype wire

// >>> verilog/pdw_ctrl.sv
// Power-down entry, wakeup sequencing and one-time main clock selection.
// Assumes the CPU issues instructions as command-register writes, one a cycle.
//
// Functional notes
// - Enter only when enter follows arm directly.
// - Enter without preceding arm is refused.
// - Satisfied key-on condition returns at once.
// - Timer 5 request set returns at once.
// - Pointers and auxiliaries undefined after wakeup.
// - Upper pointer, auxiliaries undefined after reset.
// - Watchdog active again after every wakeup.
// - No power-down with external clock input.
// - First clock-select wins; others and on-chip stop.
// - Later clock-selects ignored until reset.
// - Stabilisation wait timed by on-chip oscillator.
// - Pin A interrupt input enabled by control bit.
`default_nettype none
`include "pdw_regs.svh"
module pdw_ctrl #(
    parameter int STAB_EDGES = `PDW_STAB_EDGES
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic [3:0]  KEY_PORT_A_N,
    input  wire logic [3:0]  KEY_PORT_B_N,
    input  wire logic        EXT_IRQ_PIN_A,
    input  wire logic        EXT_IRQ_PIN_B,
    input  wire logic        TIMER5_REQUEST_FLAG,
    input  wire logic        EXT_CLOCK_STRAP,
    input  wire logic        ONCHIP_OSC,
    output logic             CPU_RUN,
    output logic             POWER_DOWN,
    output logic             DEEP_HALT,
    output logic             CERAMIC_OSC_EN,
    output logic             RC_OSC_EN,
    output logic             ONCHIP_OSC_EN,
    output logic             WDT_ACTIVE,
    output logic             IRQ
);
    // ==================================================================
    // Pin synchronisers and the stabilisation timer
    // ==================================================================
    logic [3:0] key_a_n;
    logic [3:0] key_b_n;
    logic       pin_a;
    logic       pin_b;
    logic       strap;
    logic       osc;
    logic       stab_done;

    pdw_sync #(.W(12)) u_sync (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .d     ({KEY_PORT_A_N, KEY_PORT_B_N, EXT_IRQ_PIN_A, EXT_IRQ_PIN_B,
                 EXT_CLOCK_STRAP, ONCHIP_OSC}),
        .q     ({key_a_n, key_b_n, pin_a, pin_b, strap, osc})
    );

    // The main clock is not yet trusted, so the wait counts on-chip edges.
    pdw_stab_timer #(.EDGES(STAB_EDGES)) u_stab (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .osc   (osc),
        .done  (stab_done)
    );

    // ==================================================================
    // State
    // ==================================================================
    pdw_pkg::pdw_regs_t s_r;
    pdw_pkg::pdw_regs_t s_nxt;

    logic       cmd_wr;
    logic [3:0] op;
    logic       is_enter;
    logic       key_wake;
    logic       t5;
    logic [5:0] ev;

    assign t5     = TIMER5_REQUEST_FLAG;
    assign op     = WDATA[3:0];
    assign cmd_wr = WR && (ADDR == `PDW_A_CMD)
                    && (s_r.st == pdw_pkg::ST_RUN);
    assign is_enter = cmd_wr && (op == `PDW_OP_ENTER || op == `PDW_OP_DEEP);

    // Key ports are pressed when low; the interrupt pins count when high.
    assign key_wake = |(s_r.wk_a & ~key_a_n) | |(s_r.wk_b & ~key_b_n)
                      | (s_r.wk_c[`PDW_WK_C_PIN_A] & pin_a)
                      | (s_r.wk_c[`PDW_WK_C_PIN_B] & pin_b);

    // ==================================================================
    // Next state
    // ==================================================================
    always_comb begin
        s_nxt         = s_r;
        ev            = 6'h00;
        s_nxt.pin_a_d = pin_a;
        s_nxt.pin_b_d = pin_b;

        // Edges on the interrupt pins only count while their input is on;
        // the port output path is untouched either way.
        if (s_r.ext_irq_pin_a_ctl[`PDW_INT_EN_BIT] && pin_a && !s_r.pin_a_d) begin
            ev[`PDW_EV_INT_A] = 1'b1;
        end
        if (s_r.ext_irq_pin_b_ctl[`PDW_INT_EN_BIT] && pin_b && !s_r.pin_b_d) begin
            ev[`PDW_EV_INT_B] = 1'b1;
        end

        case (s_r.st)
            pdw_pkg::ST_STAB: begin
                // The strap is caught after reset release, through the syncs.
                s_nxt.ext_clk = strap;
                if (stab_done) begin
                    s_nxt.st = pdw_pkg::ST_RUN;
                end
            end
            pdw_pkg::ST_RUN: begin
                if (cmd_wr) begin
                    s_nxt.arm = (op == `PDW_OP_ARM);
                    case (op)
                        `PDW_OP_ENTER, `PDW_OP_DEEP: begin
                            if (!s_r.arm) begin
                                ev[`PDW_EV_NO_ARM] = 1'b1;
                            end else if (s_r.ext_clk) begin
                                ev[`PDW_EV_EXT_CLK] = 1'b1;
                            end else if (key_wake || t5) begin
                                // Immediate return: the halt is entered and
                                // left in the same step.
                                ev[`PDW_EV_WAKE] = 1'b1;
                                s_nxt.wdt_en     = 1'b1;
                                s_nxt.ctx        = `PDW_CTX_POISON;
                            end else begin
                                s_nxt.st   = pdw_pkg::ST_HALT;
                                s_nxt.deep = (op == `PDW_OP_DEEP);
                            end
                        end
                        `PDW_OP_SEL_CER, `PDW_OP_SEL_RC: begin
                            if (s_r.osc_sel == 2'h0) begin
                                s_nxt.osc_sel   = (op == `PDW_OP_SEL_CER) ?
                                                  2'h1 : 2'h2;
                                s_nxt.onchip_en = 1'b0;
                            end else begin
                                ev[`PDW_EV_SEL_IGN] = 1'b1;
                            end
                        end
                        `PDW_OP_WDT_STOP: begin
                            s_nxt.wdt_stop_seen = 1'b1;
                        end
                        `PDW_OP_WDT_RST: begin
                            if (s_r.wdt_stop_seen) begin
                                s_nxt.wdt_en = 1'b0;
                            end
                        end
                        default: begin
                        end
                    endcase
                    if (op != `PDW_OP_WDT_STOP) begin
                        s_nxt.wdt_stop_seen = 1'b0;
                    end
                end else if (WR) begin
                    // Any other register write is an instruction in between.
                    s_nxt.arm           = 1'b0;
                    s_nxt.wdt_stop_seen = 1'b0;
                end
            end
            pdw_pkg::ST_HALT: begin
                if (key_wake || t5) begin
                    s_nxt.st         = pdw_pkg::ST_RUN;
                    s_nxt.deep       = 1'b0;
                    s_nxt.wdt_en     = 1'b1;
                    s_nxt.ctx        = `PDW_CTX_POISON;
                    ev[`PDW_EV_WAKE] = 1'b1;
                end
            end
            default: begin
                s_nxt.st = pdw_pkg::ST_STAB;
            end
        endcase

        // Configuration writes; the CPU is stopped outside the run state.
        if (WR && s_r.st == pdw_pkg::ST_RUN) begin
            case (ADDR)
                `PDW_A_WAKE_A:   s_nxt.wk_a     = WDATA[3:0];
                `PDW_A_WAKE_B:   s_nxt.wk_b     = WDATA[3:0];
                `PDW_A_WAKE_C:   s_nxt.wk_c     = WDATA[3:0];
                `PDW_A_EXT_IRQ_PIN_A_CTL: s_nxt.ext_irq_pin_a_ctl = WDATA[3:0];
                `PDW_A_EXT_IRQ_PIN_B_CTL: s_nxt.ext_irq_pin_b_ctl = WDATA[3:0];
                `PDW_A_CTX:      s_nxt.ctx      = WDATA[20:0];
                `PDW_A_IRQ_EN:   s_nxt.irq_en   = WDATA[5:0];
                default: begin
                end
            endcase
        end

        // A clear never loses an event of the same cycle.
        if (WR && ADDR == `PDW_A_IRQ_CLR) begin
            s_nxt.irq_stat = s_r.irq_stat & ~WDATA[5:0];
        end
        s_nxt.irq_stat = s_nxt.irq_stat | ev;
        s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_en);

        s_nxt.rdata = 32'h0;
        if (RD) begin
            case (ADDR)
                `PDW_A_WAKE_A:   s_nxt.rdata = {28'h0, s_r.wk_a};
                `PDW_A_WAKE_B:   s_nxt.rdata = {28'h0, s_r.wk_b};
                `PDW_A_WAKE_C:   s_nxt.rdata = {28'h0, s_r.wk_c};
                `PDW_A_EXT_IRQ_PIN_A_CTL: s_nxt.rdata = {28'h0, s_r.ext_irq_pin_a_ctl};
                `PDW_A_EXT_IRQ_PIN_B_CTL: s_nxt.rdata = {28'h0, s_r.ext_irq_pin_b_ctl};
                `PDW_A_STATUS:   s_nxt.rdata = {23'h0, s_r.deep, s_r.ext_clk,
                                                s_r.wdt_en, s_r.osc_sel,
                                                s_r.arm, s_r.st};
                `PDW_A_CTX:      s_nxt.rdata = {11'h0, s_r.ctx};
                `PDW_A_IRQ_STAT: s_nxt.rdata = {26'h0, s_r.irq_stat};
                `PDW_A_IRQ_EN:   s_nxt.rdata = {26'h0, s_r.irq_en};
                default:         s_nxt.rdata = 32'h0;
            endcase
        end
    end

    // ==================================================================
    // Registers
    // ==================================================================
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_r           <= '0;
            s_r.st        <= pdw_pkg::ST_STAB;
            s_r.wdt_en    <= 1'b1;
            s_r.onchip_en <= 1'b1;
            s_r.ctx       <= `PDW_CTX_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign RDATA          = s_r.rdata;
    assign CPU_RUN        = s_r.st[1];
    assign POWER_DOWN     = s_r.st[2];
    assign DEEP_HALT      = s_r.deep;
    assign CERAMIC_OSC_EN = s_r.osc_sel[0];
    assign RC_OSC_EN      = s_r.osc_sel[1];
    assign ONCHIP_OSC_EN  = s_r.onchip_en;
    assign WDT_ACTIVE     = s_r.wdt_en;
    assign IRQ            = s_r.irq;

    // ==================================================================
    // Assertions
    // ==================================================================
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    logic quiet;
    assign quiet = !key_wake && !t5 && !s_r.ext_clk;

    sequence s_arm_then_enter;
        (cmd_wr && op == `PDW_OP_ARM) ##1 (is_enter && quiet);
    endsequence

    sequence s_halt_wake;
        (s_r.st == pdw_pkg::ST_HALT) && (key_wake || t5);
    endsequence

    property p_enter;
        s_arm_then_enter |=> POWER_DOWN && !CPU_RUN;
    endproperty
    a_enter: assert property (p_enter) else $error("armed enter did not halt");

    property p_no_arm;
        (is_enter && !s_r.arm) |=> !POWER_DOWN ##1 !POWER_DOWN;
    endproperty
    a_no_arm: assert property (p_no_arm) else $error("unarmed enter halted");

    property p_keyon;
        (is_enter && s_r.arm && key_wake) |=> CPU_RUN && s_r.irq_stat[0];
    endproperty
    a_keyon: assert property (p_keyon) else $error("key-on did not return");

    property p_t5;
        (is_enter && s_r.arm && t5) |=> !POWER_DOWN;
    endproperty
    a_t5: assert property (p_t5) else $error("timer 5 flag ignored");

    property p_ctx;
        s_halt_wake |=> s_r.ctx == `PDW_CTX_POISON && CPU_RUN;
    endproperty
    a_ctx: assert property (p_ctx) else $error("context not undefined");

    property p_rst_ctx;
        (s_r.st == pdw_pkg::ST_STAB) |-> s_r.ctx == `PDW_CTX_RST;
    endproperty
    a_rst_ctx: assert property (p_rst_ctx) else $error("reset context wrong");

    property p_wdt;
        s_halt_wake |=> WDT_ACTIVE;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog not active");

    property p_ext_clk;
        s_r.ext_clk |-> !POWER_DOWN;
    endproperty
    a_ext_clk: assert property (p_ext_clk) else $error("halt with ext clock");

    property p_sel_first;
        (cmd_wr && op == `PDW_OP_SEL_RC && s_r.osc_sel == 2'h0)
            |=> RC_OSC_EN && !CERAMIC_OSC_EN && !ONCHIP_OSC_EN;
    endproperty
    a_sel_first: assert property (p_sel_first) else $error("first select lost");

    property p_sel_once;
        (s_r.osc_sel != 2'h0) |=> $stable(s_r.osc_sel);
    endproperty
    a_sel_once: assert property (p_sel_once) else $error("clock reselected");

    property p_stab;
        (s_r.st == pdw_pkg::ST_STAB && !stab_done) |=> !CPU_RUN;
    endproperty
    a_stab: assert property (p_stab) else $error("run before wait end");

    property p_int_a;
        (s_r.ext_irq_pin_a_ctl[`PDW_INT_EN_BIT] && pin_a && !s_r.pin_a_d)
            |=> s_r.irq_stat[`PDW_EV_INT_A];
    endproperty
    a_int_a: assert property (p_int_a) else $error("pin A edge lost");

    property p_stay;
        (POWER_DOWN && !key_wake && !t5) |=> POWER_DOWN;
    endproperty
    a_stay: assert property (p_stay) else $error("left halt unprompted");
endmodule // pdw_ctrl
`default_nettype wire

// >>> testbench/pdw_pins.sv
// Pin-side model of the power-down controller: key ports, interrupt pins and on-chip oscillator.
// Assumes the bench sets the request inputs just after rising edges of clk.
`default_nettype none
module pdw_pins (
    input  wire logic       clk,
    input  wire logic [3:0] press_a,
    input  wire logic [3:0] press_b,
    input  wire logic       lvl_a,
    input  wire logic       lvl_b,
    input  wire logic       osc_on,
    input  wire logic       osc_en,
    output logic      [3:0] key_a_n,
    output logic      [3:0] key_b_n,
    output logic            pin_a,
    output logic            pin_b,
    output logic            osc
);
    timeunit 1ns;
    timeprecision 100ps;
    // ====================================================================
    // Pins
    // Key lines carry pull-ups, so a released key reads high.
    always_ff @(posedge clk) begin
        key_a_n <= ~press_a;
        key_b_n <= ~press_b;
        pin_a   <= lvl_a;
        pin_b   <= lvl_b;
    end
    // ====================================================================
    // Oscillator
    // The period is not a multiple of the ref clock, so edges drift in phase.
    initial osc = 1'b0;
    always #37 osc = (osc_on && osc_en) ? ~osc : 1'b0;
endmodule // pdw_pins
`default_nettype wire

// >>> testbench/pdw_ctrl_tb.sv
// Self-checking bench of the power-down and wakeup controller.
// Assumes the register header is on the include path and a short stabilisation count.
`default_nettype none
`include "pdw_regs.svh"
module pdw_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst_n, wr, rd, la, lb, t5, strap, osc_on;
    logic [3:0]  addr, pa, pb, ka, kb;
    logic [31:0] wdata, rdata;
    logic        pin_a, pin_b, osc, run, pd, deep, cer, rc, onc, wdt, irq;
    int          n_fail, n_checks;

    pdw_pins pins (.clk(clk), .press_a(pa), .press_b(pb), .lvl_a(la), .lvl_b(lb),
        .osc_on(osc_on), .osc_en(onc), .key_a_n(ka), .key_b_n(kb), .pin_a(pin_a),
        .pin_b(pin_b), .osc(osc));
    pdw_ctrl #(.STAB_EDGES(3)) dut (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .KEY_PORT_A_N(ka),
        .KEY_PORT_B_N(kb), .EXT_IRQ_PIN_A(pin_a), .EXT_IRQ_PIN_B(pin_b),
        .TIMER5_REQUEST_FLAG(t5), .EXT_CLOCK_STRAP(strap), .ONCHIP_OSC(osc),
        .CPU_RUN(run), .POWER_DOWN(pd), .DEEP_HALT(deep), .CERAMIC_OSC_EN(cer),
        .RC_OSC_EN(rc), .ONCHIP_OSC_EN(onc), .WDT_ACTIVE(wdt), .IRQ(irq));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ====================================================================
    // Tasks
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string msg);
        chk({31'h0, got}, {31'h0, exp}, msg);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic cmd(input logic [3:0] op);
        wr_reg(`PDW_A_CMD, {28'h0, op});
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string msg);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, msg);
    endtask
    task automatic wait_run();
        int i;
        i = 0;
        while (run !== 1'b1 && i < 300) begin
            @(posedge clk);
            i++;
        end
        #1;
        chk1(run, 1'b1, "cpu not running");
    endtask
    task automatic clr();
        wr_reg(`PDW_A_IRQ_CLR, 32'h3f);
    endtask
    // ====================================================================
    // Tests
    initial begin
        n_fail = 0;
        n_checks = 0;
        {rst_n, wr, rd, la, lb, t5, strap, osc_on} = 8'h00;
        {addr, pa, pb} = 12'h000;
        wdata = 32'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk1(onc, 1'b1, "on-chip osc enable");
        chk1(wdt, 1'b1, "watchdog after reset");
        repeat (40) @(posedge clk);
        #1;
        chk1(run, 1'b0, "ran without on-chip osc");
        osc_on <= 1'b1;
        wait_run();
        rd_chk(`PDW_A_STATUS, 32'h42, "status after start");
        rd_chk(`PDW_A_CTX, {11'h0, `PDW_CTX_RST}, "ctx after reset");
        // Clock selection comes first in the start-up routine.
        cmd(`PDW_OP_SEL_CER);
        chk({29'h0, cer, rc, onc}, 32'h4, "ceramic select");
        clr();
        cmd(`PDW_OP_SEL_RC);
        chk({30'h0, cer, rc}, 32'h2, "second select");
        rd_chk(`PDW_A_IRQ_STAT, 32'h8, "ignored select flag");
        // Enter without arm, then arm broken by another write.
        wr_reg(`PDW_A_IRQ_EN, 32'h2);
        clr();
        cmd(`PDW_OP_ENTER);
        chk1(pd, 1'b0, "enter without arm");
        rd_chk(`PDW_A_IRQ_STAT, 32'h2, "refused flag");
        chk1(irq, 1'b1, "irq raised");
        clr();
        wr_reg(`PDW_A_IRQ_EN, 32'h0);
        cmd(`PDW_OP_DEEP);
        repeat (2) @(posedge clk);
        #1;
        chk1(irq, 1'b0, "irq masked");
        cmd(`PDW_OP_ARM);
        wr_reg(`PDW_A_WAKE_A, 32'h1);
        cmd(`PDW_OP_ENTER);
        chk1(pd, 1'b0, "arm not adjacent");
        // Proper entry, hold, and wake by key A0.
        wr_reg(`PDW_A_CTX, 32'h0);
        cmd(`PDW_OP_INT_MASK);
        cmd(`PDW_OP_WDT_STOP);
        cmd(`PDW_OP_WDT_RST);
        chk1(wdt, 1'b0, "watchdog stopped");
        cmd(`PDW_OP_ARM);
        cmd(`PDW_OP_ENTER);
        chk({30'h0, run, pd}, 32'h1, "power down");
        repeat (50) @(posedge clk);
        #1;
        chk1(pd, 1'b1, "stays halted");
        pa <= 4'h1;
        wait_run();
        chk({30'h0, pd, wdt}, 32'h1, "after wake");
        rd_chk(`PDW_A_CTX, {11'h0, `PDW_CTX_POISON}, "ctx after wake");
        pa <= 4'h0;
        // Key B already pressed: return at once.
        wr_reg(`PDW_A_WAKE_B, 32'h8);
        pb <= 4'h8;
        clr();
        cmd(`PDW_OP_ARM);
        cmd(`PDW_OP_ENTER);
        chk({30'h0, run, pd}, 32'h2, "immediate key return");
        rd_chk(`PDW_A_IRQ_STAT, 32'h1, "wake flag");
        pb <= 4'h0;
        repeat (4) @(posedge clk);
        // Timer 5 request set at entry.
        t5 <= 1'b1;
        cmd(`PDW_OP_ARM);
        cmd(`PDW_OP_ENTER);
        chk({30'h0, run, pd}, 32'h2, "timer5 return");
        t5 <= 1'b0;
        // Deep halt, woken by pin A with its input enabled.
        wr_reg(`PDW_A_WAKE_C, 32'h1);
        wr_reg(`PDW_A_EXT_IRQ_PIN_A_CTL, 32'h8);
        clr();
        cmd(`PDW_OP_ARM);
        cmd(`PDW_OP_DEEP);
        chk({30'h0, deep, pd}, 32'h3, "deep halt");
        la <= 1'b1;
        wait_run();
        chk1(deep, 1'b0, "deep left");
        rd_chk(`PDW_A_IRQ_STAT, 32'h11, "pin a event and wake");
        la <= 1'b0;
        // Pin wakeups invalidated; pin B must not wake, timer 5 must.
        wr_reg(`PDW_A_EXT_IRQ_PIN_A_CTL, 32'h0);
        wr_reg(`PDW_A_WAKE_C, 32'h0);
        cmd(`PDW_OP_ARM);
        cmd(`PDW_OP_ENTER);
        lb <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        chk1(pd, 1'b1, "pin b disabled");
        t5 <= 1'b1;
        wait_run();
        {t5, lb} <= 2'b00;
        // Pin B edge is recorded once its input is enabled.
        wr_reg(`PDW_A_EXT_IRQ_PIN_B_CTL, 32'h8);
        clr();
        lb <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(`PDW_A_IRQ_STAT, 32'h20, "pin b event");
        lb <= 1'b0;
        // Reset in mid-run with an external main clock.
        strap <= 1'b1;
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({29'h0, cer, rc, onc}, 32'h1, "selection reset");
        wait_run();
        cmd(`PDW_OP_SEL_RC);
        chk1(rc, 1'b1, "rc select");
        cmd(`PDW_OP_ARM);
        cmd(`PDW_OP_ENTER);
        chk1(pd, 1'b0, "ext clock entry");
        rd_chk(`PDW_A_IRQ_STAT, 32'h4, "ext clock flag");
        rd_chk(4'hf, 32'h0, "unmapped read");
        end_sim();
    end

    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
endmodule // pdw_ctrl_tb
`default_nettype wire
